// ===== verilog/udf_pkg.sv
// constants, codes and carriers for the up/down frequency reference block
package udf_pkg;

  // frequency values are in 0.1 % of max_output_frequency
  localparam int FREQ_W = 11;
  typedef logic [FREQ_W-1:0] udf_freq_t;

  localparam udf_freq_t FREQ_LIMIT_MAX = 11'h44c;  // 110.0 %
  localparam udf_freq_t UPPER_RESET    = 11'h3e8;  // 100.0 %
  localparam udf_freq_t LOWER_RESET    = 11'h000;  // 0.0 %
  localparam udf_freq_t MASTER_RESET   = 11'h000;  // 0.0 %
  localparam udf_freq_t ZERO_FREQ      = 11'h000;
  localparam udf_freq_t ACCEL_RESET    = 11'h001;
  localparam udf_freq_t DECEL_RESET    = 11'h001;
  localparam udf_freq_t UPDN_RESET     = 11'h001;

  // contact terminals and input function codes
  localparam int NUM_TERM = 10;
  localparam logic [7:0] FN_NONE      = 8'h00;
  localparam logic [7:0] FN_RAMP_HOLD = 8'h0a;
  localparam logic [7:0] FN_RAISE     = 8'h10;
  localparam logic [7:0] FN_LOWER     = 8'h11;

  localparam logic [1:0] RUN_SRC_TERMINAL = 2'h1;
  localparam logic [1:0] RUN_SRC_RESET    = 2'h1;
  localparam logic       HOLD_MEM_RESET   = 1'b0;

  // timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int TICK_NS       = 1000000;  // 1 ms ramp tick
  localparam int TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;
  localparam int DEBOUNCE_NS   = 10000000; // 10 ms contact debounce
  localparam int DEBOUNCE_CYC  = DEBOUNCE_NS / CLK_PERIOD_NS;
  localparam int TICK_CNT_W    = 20;
  localparam int DB_CNT_W      = 20;

  // register byte offsets
  localparam int ADR_W = 8;
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_UPPER  = 8'h04;
  localparam logic [7:0] REG_LOWER  = 8'h08;
  localparam logic [7:0] REG_MASTER = 8'h0c;
  localparam logic [7:0] REG_ACCEL  = 8'h10;
  localparam logic [7:0] REG_DECEL  = 8'h14;
  localparam logic [7:0] REG_UPDN   = 8'h18;
  localparam logic [7:0] REG_STATUS = 8'h1c;
  localparam logic [7:0] REG_REF    = 8'h20;
  localparam logic [7:0] REG_OUT    = 8'h24;
  localparam logic [7:0] REG_MEM    = 8'h28;
  localparam logic [7:0] REG_FSEL0  = 8'h40;

  // control register fields
  localparam int CTRL_HOLD_MEM = 0;
  localparam int CTRL_RUN_SRC  = 1;
  localparam int CTRL_SW_RUN   = 3;

  typedef struct packed {
    logic       sw_run;
    logic [1:0] run_src;
    logic       hold_mem;
  } udf_ctrl_t;

  typedef struct packed {
    logic lower;
    logic raise;
    logic hold;
    logic running;
    logic multistep_dis;
    logic agree;
    logic cfg_err;
  } udf_status_t;

  typedef enum logic {UDF_STOP, UDF_RUN} udf_state_t;

endpackage : udf_pkg

// ===== verilog/udf_debounce.sv
// two-flop synchroniser and debounce filter for contact inputs
`timescale 1ns/1ns
module udf_debounce
  import udf_pkg::*;
#(
  parameter int N         = 11,
  parameter int DB_CYCLES = DEBOUNCE_CYC
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         ce_i,
  input  wire logic [N-1:0] raw_i,
  output logic      [N-1:0] clean_o
);

  localparam logic [DB_CNT_W-1:0] DB_LAST = DB_CNT_W'(DB_CYCLES - 1);

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_bit
      logic                s1_r, s2_r, st_r;
      logic                s1_nxt, s2_nxt, st_nxt;
      logic [DB_CNT_W-1:0] cnt_r, cnt_nxt;

      always_comb begin
        s1_nxt  = raw_i[g];
        s2_nxt  = s1_r;
        st_nxt  = st_r;
        cnt_nxt = '0;
        // a level must differ for the full window before it is taken
        if (s2_r != st_r) begin
          if (cnt_r == DB_LAST) begin
            st_nxt = s2_r;
          end else begin
            cnt_nxt = cnt_r + DB_CNT_W'(1);
          end
        end
      end

      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          s1_r  <= 1'b0;
          s2_r  <= 1'b0;
          st_r  <= 1'b0;
          cnt_r <= '0;
        end else if (ce_i) begin
          s1_r  <= s1_nxt;
          s2_r  <= s2_nxt;
          st_r  <= st_nxt;
          cnt_r <= cnt_nxt;
        end
      end

      assign clean_o[g] = st_r;
    end
  endgenerate

endmodule : udf_debounce

// ===== verilog/udf_ramp.sv
// acceleration ramp: output frequency walks toward the target
`timescale 1ns/1ns
module udf_ramp
  import udf_pkg::*;
(
  input  wire logic      clk_i,
  input  wire logic      rst_i,
  input  wire logic      ce_i,
  input  wire logic      tick_i,
  input  wire udf_freq_t target_i,
  input  wire logic      hold_i,
  input  wire logic      load_i,
  input  wire udf_freq_t load_val_i,
  input  wire udf_freq_t accel_step_i,
  input  wire udf_freq_t decel_step_i,
  output udf_freq_t      freq_o,
  output logic           busy_o
);

  udf_freq_t freq_r, freq_nxt;
  logic      busy_r, busy_nxt;

  always_comb begin
    freq_nxt = freq_r;
    if (load_i) begin
      freq_nxt = load_val_i;
    end else if (hold_i) begin
      freq_nxt = freq_r;  // RL18 RL4
    end else if (tick_i) begin
      // RL6
      if (target_i > freq_r) begin
        freq_nxt = (target_i - freq_r > accel_step_i) ? freq_r + accel_step_i : target_i;
      end else if (target_i < freq_r) begin
        freq_nxt = (freq_r - target_i > decel_step_i) ? freq_r - decel_step_i : target_i;
      end
    end
    busy_nxt = (freq_nxt != target_i) && !hold_i;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      freq_r <= ZERO_FREQ;
      busy_r <= 1'b0;
    end else if (ce_i) begin
      freq_r <= freq_nxt;
      busy_r <= busy_nxt;
    end
  end

  assign freq_o = freq_r;
  assign busy_o = busy_r;

endmodule : udf_ramp

// ===== verilog/udf_top.sv
// up/down frequency reference logic with a classic wishbone register slave
// Function
// RL1: hold memory on keeps the ramp-hold frozen output frequency through power-off.
// RL2: operator applies run with ramp hold on to resume at retained frequency.
// RL3: hold memory off, run during ramp hold forces output frequency to zero.
// RL4: ramp hold overrides an ongoing deceleration, freezing it.
// RL5: selector code 10 makes a terminal raise, code 11 makes it lower.
// RL6: output frequency follows the reference at accel and decel rates.
// RL7: run source must be terminals (setting 1) when raise/lower is used.
// RL8: reference clamped to upper limit, 0.0 to 110.0 %, default 100.0 %.
// RL9: lower limit is the largest of analog input, lower limit, master floor.
// RL10: raise/lower reference stays within upper and lower limits, analog as floor.
// RL11: config error when only one of raise and lower is assigned.
// RL12: config error when raise/lower and ramp hold are both assigned.
// RL13: run with raise/lower active accelerates to the effective lower limit.
// RL14: multi-step speed selection disabled while raise/lower is in use.
// RL15: hold memory on keeps raise/lower reference, run after power-up returns to it.
// RL16: raise or lower pressed while running clears the retained reference to zero.
// RL17: frequency agree when running and neither accelerating nor decelerating.
// RL18: code A selects ramp hold, freezing accel and decel until released.
// RL19: hold memory setting 0 disabled, 1 enabled, default disabled.
// RL20: raise alone increases, lower alone decreases, both or neither hold.
// RL21: raise and lower inputs are synchronised and debounced before use.
`timescale 1ns/1ns
module udf_top
  import udf_pkg::*;
#(
  parameter int TICK_CYC = TICK_CYCLES,
  parameter int DB_CYC   = DEBOUNCE_CYC
) (
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  input  wire logic                ce_i,
  input  wire logic                cyc_i,
  input  wire logic                stb_i,
  input  wire logic                we_i,
  input  wire logic [ADR_W-1:0]    adr_i,
  input  wire logic [3:0]          sel_i,
  input  wire logic [31:0]         dat_i,
  output logic      [31:0]         dat_o,
  output logic                     ack_o,
  input  wire logic [NUM_TERM-1:0] contact_input_terminals_i,
  input  wire logic                run_cmd_i,
  input  wire logic                power_down_i,
  input  wire udf_freq_t           analog_reference_input_i,
  output udf_freq_t                out_freq_o,
  output logic                     freq_agree_o,
  output logic                     input_config_error_o,
  output logic                     multistep_disable_o
);

  localparam logic [TICK_CNT_W-1:0] TICK_LAST = TICK_CNT_W'(TICK_CYC - 1);

  // clamp with the upper limit winning over a floor above it
  function automatic udf_freq_t clampf(udf_freq_t v, udf_freq_t lo, udf_freq_t hi);
    udf_freq_t r;
    r = v;
    if (r < lo) r = lo;
    if (r > hi) r = hi;
    return r;
  endfunction : clampf

  function automatic logic [31:0] merge(logic [31:0] old, logic [31:0] d, logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) r[b*8 +: 8] = d[b*8 +: 8];
    end
    return r;
  endfunction : merge

  function automatic udf_freq_t limw(logic [31:0] w);
    udf_freq_t r;
    r = w[FREQ_W-1:0];
    if (w[31:FREQ_W] != '0 || r > FREQ_LIMIT_MAX) r = FREQ_LIMIT_MAX;
    return r;
  endfunction : limw

  // ---------------- contact inputs and analog reference ----------------
  logic [NUM_TERM:0] db_clean;
  logic [NUM_TERM-1:0] term_db;
  logic                run_term;

  udf_debounce #(.N(NUM_TERM + 1), .DB_CYCLES(DB_CYC)) u_db (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .ce_i    (ce_i),
    .raw_i   ({run_cmd_i, contact_input_terminals_i}),
    .clean_o (db_clean)
  );  // RL21
  assign term_db  = db_clean[NUM_TERM-1:0];
  assign run_term = db_clean[NUM_TERM];

  // analog word and power-down level pass two flops; a changing word may tear
  udf_freq_t an_s1_r, an_s2_r;
  logic      pd_s1_r, pd_s2_r;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      an_s1_r <= ZERO_FREQ;
      an_s2_r <= ZERO_FREQ;
      pd_s1_r <= 1'b0;
      pd_s2_r <= 1'b0;
    end else if (ce_i) begin
      an_s1_r <= analog_reference_input_i;
      an_s2_r <= an_s1_r;
      pd_s1_r <= power_down_i;
      pd_s2_r <= pd_s1_r;
    end
  end

  // ---------------- registers ----------------
  udf_ctrl_t ctrl_r, ctrl_nxt;
  udf_freq_t upper_r, upper_nxt, lower_r, lower_nxt, master_r, master_nxt;
  udf_freq_t accel_r, accel_nxt, decel_r, decel_nxt, updn_r, updn_nxt;
  logic [7:0] fsel_r [NUM_TERM];
  logic [7:0] fsel_nxt [NUM_TERM];
  logic [31:0] dat_r, dat_nxt;
  logic        ack_r, ack_nxt;
  udf_status_t stat;

  // ---------------- function decode per terminal ----------------
  logic [NUM_TERM-1:0] is_raise, is_lower, is_hold, raise_v, lower_v, hold_v;
  genvar g;
  generate
    for (g = 0; g < NUM_TERM; g++) begin : g_term
      assign is_raise[g] = (fsel_r[g] == FN_RAISE);      // RL5
      assign is_lower[g] = (fsel_r[g] == FN_LOWER);      // RL5
      assign is_hold[g]  = (fsel_r[g] == FN_RAMP_HOLD);  // RL18
      assign raise_v[g]  = is_raise[g] & term_db[g];
      assign lower_v[g]  = is_lower[g] & term_db[g];
      assign hold_v[g]   = is_hold[g] & term_db[g];
    end
  endgenerate

  logic cfg_err, updn_act, raise_in, lower_in, hold_in;
  assign cfg_err  = ((|is_raise) != (|is_lower))            // RL11
                  | ((|is_raise) & (|is_lower) & (|is_hold)); // RL12
  assign updn_act = (|is_raise) & (|is_lower) & ~cfg_err;
  assign raise_in = |raise_v;
  assign lower_in = |lower_v;
  assign hold_in  = (|hold_v) & ~cfg_err;

  // ---------------- run control and reference ----------------
  udf_state_t state_r, state_nxt;
  udf_freq_t  ref_r, ref_nxt, mem_r, mem_nxt, target, floor_f, an_ref;
  logic [TICK_CNT_W-1:0] tick_cnt_r, tick_cnt_nxt;
  logic       tick, run_raw, run_eff, ramp_load, agree_r, agree_nxt;
  logic       err_r, msd_r;
  udf_freq_t  ramp_load_val, ramp_freq;
  logic       ramp_busy;

  assign tick    = (tick_cnt_r == TICK_LAST);
  assign run_raw = (ctrl_r.run_src == RUN_SRC_TERMINAL) ? run_term : ctrl_r.sw_run; // RL7
  assign run_eff = run_raw & ~pd_s2_r & ~cfg_err;

  always_comb begin
    // RL9 RL10
    floor_f = (an_s2_r > lower_r) ? an_s2_r : lower_r;
    if (master_r > floor_f) floor_f = master_r;
    an_ref = clampf(an_s2_r, lower_r > master_r ? lower_r : master_r, upper_r); // RL8
  end

  always_comb begin
    state_nxt     = state_r;
    ref_nxt       = ref_r;
    mem_nxt       = mem_r;
    ramp_load     = 1'b0;
    ramp_load_val = ZERO_FREQ;
    tick_cnt_nxt  = tick ? '0 : tick_cnt_r + TICK_CNT_W'(1);
    case (state_r)
      UDF_STOP: begin
        if (run_eff) begin
          state_nxt = UDF_RUN;
          if (hold_in) begin
            ramp_load     = 1'b1;
            ramp_load_val = ctrl_r.hold_mem ? mem_r : ZERO_FREQ; // RL1 RL2 RL3
          end
          if (updn_act) begin
            // RL13 RL15
            ref_nxt = ctrl_r.hold_mem ? clampf(mem_r, floor_f, upper_r) : floor_f;
          end
        end
      end
      UDF_RUN: begin
        if (!run_eff) begin
          state_nxt = UDF_STOP;
        end else if (updn_act) begin
          // RL20
          if (tick && raise_in && !lower_in) begin
            ref_nxt = (upper_r - ref_r > updn_r) ? ref_r + updn_r : upper_r;
          end else if (tick && lower_in && !raise_in) begin
            ref_nxt = (ref_r > updn_r) ? ref_r - updn_r : ZERO_FREQ;
          end
          ref_nxt = clampf(ref_nxt, floor_f, upper_r); // RL10 RL8
          mem_nxt = (raise_in || lower_in) ? ZERO_FREQ : ref_r; // RL16 RL15
        end else if (hold_in && ctrl_r.hold_mem) begin
          mem_nxt = ramp_freq; // RL1
        end
      end
      default: state_nxt = UDF_STOP;
    endcase
    // power loss stops the drive; only hold memory keeps the stored value
    if (pd_s2_r) begin
      ramp_load     = 1'b1;
      ramp_load_val = ZERO_FREQ;
      if (!ctrl_r.hold_mem) mem_nxt = ZERO_FREQ; // RL19
    end
    if (state_r == UDF_STOP) begin
      target = ZERO_FREQ;
    end else begin
      target = updn_act ? ref_r : an_ref;
    end
    agree_nxt = (state_r == UDF_RUN) && !ramp_busy && (ramp_freq == target); // RL17
  end

  udf_ramp u_ramp (
    .clk_i        (clk_i),
    .rst_i        (rst_i),
    .ce_i         (ce_i),
    .tick_i       (tick),
    .target_i     (target),
    .hold_i       (hold_in),
    .load_i       (ramp_load),
    .load_val_i   (ramp_load_val),
    .accel_step_i (accel_r),
    .decel_step_i (decel_r),
    .freq_o       (ramp_freq),
    .busy_o       (ramp_busy)
  ); // RL6

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r    <= UDF_STOP;
      ref_r      <= ZERO_FREQ;
      mem_r      <= ZERO_FREQ;
      tick_cnt_r <= '0;
      agree_r    <= 1'b0;
      err_r      <= 1'b0;
      msd_r      <= 1'b0;
    end else if (ce_i) begin
      state_r    <= state_nxt;
      ref_r      <= ref_nxt;
      mem_r      <= mem_nxt;
      tick_cnt_r <= tick_cnt_nxt;
      agree_r    <= agree_nxt;
      err_r      <= cfg_err;
      msd_r      <= updn_act; // RL14
    end
  end

  // ---------------- wishbone slave ----------------
  logic        req, wr;
  logic [31:0] ctrl_w;
  assign req    = cyc_i & stb_i & ~ack_r;
  assign wr     = req & we_i;
  assign ctrl_w = {28'h0, ctrl_r};
  assign stat   = '{lower: lower_in, raise: raise_in, hold: hold_in,
                    running: (state_r == UDF_RUN), multistep_dis: msd_r,
                    agree: agree_r, cfg_err: err_r};

  always_comb begin
    logic [31:0] w;
    w          = '0;
    ctrl_nxt   = ctrl_r;
    upper_nxt  = upper_r;
    lower_nxt  = lower_r;
    master_nxt = master_r;
    accel_nxt  = accel_r;
    decel_nxt  = decel_r;
    updn_nxt   = updn_r;
    for (int i = 0; i < NUM_TERM; i++) fsel_nxt[i] = fsel_r[i];
    ack_nxt = req;
    dat_nxt = '0;
    if (wr) begin
      case (adr_i)
        REG_CTRL: begin
          w = merge(ctrl_w, dat_i, sel_i);
          ctrl_nxt = udf_ctrl_t'(w[3:0]); // RL19
        end
        REG_UPPER:  upper_nxt  = limw(merge({21'h0, upper_r}, dat_i, sel_i)); // RL8
        REG_LOWER:  lower_nxt  = limw(merge({21'h0, lower_r}, dat_i, sel_i));
        REG_MASTER: master_nxt = limw(merge({21'h0, master_r}, dat_i, sel_i));
        REG_ACCEL:  accel_nxt  = limw(merge({21'h0, accel_r}, dat_i, sel_i));
        REG_DECEL:  decel_nxt  = limw(merge({21'h0, decel_r}, dat_i, sel_i));
        REG_UPDN:   updn_nxt   = limw(merge({21'h0, updn_r}, dat_i, sel_i));
        default: begin
          for (int i = 0; i < NUM_TERM; i++) begin
            if (adr_i == REG_FSEL0 + 8'(4 * i) && sel_i[0]) fsel_nxt[i] = dat_i[7:0];
          end
        end
      endcase
    end else if (req) begin
      case (adr_i)
        REG_CTRL:   dat_nxt = ctrl_w;
        REG_UPPER:  dat_nxt = {21'h0, upper_r};
        REG_LOWER:  dat_nxt = {21'h0, lower_r};
        REG_MASTER: dat_nxt = {21'h0, master_r};
        REG_ACCEL:  dat_nxt = {21'h0, accel_r};
        REG_DECEL:  dat_nxt = {21'h0, decel_r};
        REG_UPDN:   dat_nxt = {21'h0, updn_r};
        REG_STATUS: dat_nxt = {25'h0, stat};
        REG_REF:    dat_nxt = {21'h0, ref_r};
        REG_OUT:    dat_nxt = {21'h0, ramp_freq};
        REG_MEM:    dat_nxt = {21'h0, mem_r};
        default: begin
          for (int i = 0; i < NUM_TERM; i++) begin
            if (adr_i == REG_FSEL0 + 8'(4 * i)) dat_nxt = {24'h0, fsel_r[i]};
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r   <= '{sw_run: 1'b0, run_src: RUN_SRC_RESET, hold_mem: HOLD_MEM_RESET};
      upper_r  <= UPPER_RESET;
      lower_r  <= LOWER_RESET;
      master_r <= MASTER_RESET;
      accel_r  <= ACCEL_RESET;
      decel_r  <= DECEL_RESET;
      updn_r   <= UPDN_RESET;
      for (int i = 0; i < NUM_TERM; i++) fsel_r[i] <= FN_NONE;
      ack_r    <= 1'b0;
      dat_r    <= '0;
    end else if (ce_i) begin
      ctrl_r   <= ctrl_nxt;
      upper_r  <= upper_nxt;
      lower_r  <= lower_nxt;
      master_r <= master_nxt;
      accel_r  <= accel_nxt;
      decel_r  <= decel_nxt;
      updn_r   <= updn_nxt;
      for (int i = 0; i < NUM_TERM; i++) fsel_r[i] <= fsel_nxt[i];
      ack_r    <= ack_nxt;
      dat_r    <= dat_nxt;
    end
  end

  assign dat_o                = dat_r;
  assign ack_o                = ack_r;
  assign out_freq_o           = ramp_freq;
  assign freq_agree_o         = agree_r;
  assign input_config_error_o = err_r;
  assign multistep_disable_o  = msd_r;

endmodule : udf_top

// ===== dv/udf_props.sv
// port-level assertions for udf_top
`timescale 1ns/1ns
module udf_props
  import udf_pkg::*;
#(
  parameter int TICK_CYC = TICK_CYCLES,
  parameter int DB_CYC   = DEBOUNCE_CYC
) (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        ce_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  input wire logic        power_down_i,
  input wire udf_freq_t   out_freq_o,
  input wire logic        freq_agree_o,
  input wire logic        input_config_error_o,
  input wire logic        multistep_disable_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_req;
    cyc_i && stb_i && !ack_o && ce_i;
  endsequence
  sequence s_step;
    $changed(out_freq_o) && !power_down_i;
  endsequence
  a_ack_next: assert property (s_req |=> ack_o)
    else $error("request not answered next cycle");
  a_ack_pulse: assert property (ack_o && ce_i |=> !ack_o)
    else $error("ack longer than one cycle");
  a_dat_idle: assert property (!ack_o |-> dat_o == 32'h0)
    else $error("read data without ack");
  a_out_upper: assert property (out_freq_o <= FREQ_LIMIT_MAX)
    else $error("output above limit");
  a_step_gap: assert property (s_step |=> $stable(out_freq_o) [*2])
    else $error("output stepped faster than the tick");
  a_agree_still: assert property ((freq_agree_o && !power_down_i) [*3] |-> $stable(out_freq_o))
    else $error("output moved while agree");
  a_power_zero: assert property (power_down_i [*5] |-> out_freq_o == ZERO_FREQ)
    else $error("output not zero at power off");
  a_err_no_ms: assert property (input_config_error_o |-> !multistep_disable_o ##1 !freq_agree_o)
    else $error("multistep or agree with config error");
endmodule : udf_props

bind udf_top udf_props #(.TICK_CYC(TICK_CYC), .DB_CYC(DB_CYC)) u_props (
  .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .cyc_i(cyc_i), .stb_i(stb_i),
  .dat_o(dat_o), .ack_o(ack_o), .power_down_i(power_down_i),
  .out_freq_o(out_freq_o), .freq_agree_o(freq_agree_o),
  .input_config_error_o(input_config_error_o),
  .multistep_disable_o(multistep_disable_o));

// ===== dv/udf_contacts.sv
// contact switches and run command source with contact chatter
`timescale 1ns/1ns
module udf_contacts #(
  parameter int BOUNCE = 3
) (
  input  wire logic       clk_i,
  input  wire logic [3:0] cmd_i,
  input  wire logic [6:0] noise_i,
  output logic      [9:0] term_o,
  output logic            run_o
);
  // cmd is {run, hold, lower, raise}; chatter toggles each cycle, then settles to cmd after BOUNCE cycles
  logic [3:0] sw_r = 4'h0;
  int         cnt[4] = '{default: 0};
  always @(posedge clk_i) begin
    for (int i = 0; i < 4; i++) begin
      if (cnt[i] > 0) begin
        cnt[i] <= cnt[i] - 1;
        sw_r[i] <= (cnt[i] == 1) ? cmd_i[i] : ~sw_r[i];
      end else if (sw_r[i] !== cmd_i[i]) begin
        if (BOUNCE == 0) sw_r[i] <= cmd_i[i];
        else cnt[i] <= BOUNCE;
      end
    end
  end
  assign term_o = {noise_i, sw_r[2:0]};
  assign run_o  = sw_r[3];
endmodule : udf_contacts

// ===== dv/udf_top_tb_top.sv
// self-checking bench for the up/down frequency reference block
`timescale 1ns/1ns
module udf_top_tb_top
  import udf_pkg::*;
;
  logic        clk_i = 1'h0;
  logic        rst_i = 1'h1;
  logic        cyc_i = 1'h0;
  logic        stb_i = 1'h0;
  logic        we_i  = 1'h0;
  logic        pd_i  = 1'h0;
  logic [3:0]  sel_i = 4'h0;
  logic [7:0]  adr_i = 8'h0;
  logic [31:0] dat_i = 32'h0;
  logic [31:0] dat_o;
  logic        ack_o;
  logic        run_cmd_i;
  logic        agree;
  logic        cfg_err;
  logic        ms_dis;
  logic [9:0]  term;
  logic [3:0]  cmd   = 4'h0;
  logic [6:0]  noise = 7'h0;
  udf_freq_t   ana   = 11'h0;
  udf_freq_t   out_f;
  udf_freq_t   a;
  logic [31:0] exp_q[$];
  logic [11:0] cfg_t[4] = '{12'h042, 12'h445, 12'h82a, 12'h801};
  int          fails = 0;
  int          cmp_count = 0;
  int          cyc_n = 0;
  int          seed = 65837;

  initial forever #20 clk_i = ~clk_i;

  udf_top #(.TICK_CYC(4), .DB_CYC(2)) u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'h1), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
    .ack_o(ack_o), .contact_input_terminals_i(term), .run_cmd_i(run_cmd_i),
    .power_down_i(pd_i), .analog_reference_input_i(ana), .out_freq_o(out_f),
    .freq_agree_o(agree), .input_config_error_o(cfg_err),
    .multistep_disable_o(ms_dis));

  udf_contacts #(.BOUNCE(3)) u_sw (
    .clk_i(clk_i), .cmd_i(cmd), .noise_i(noise), .term_o(term), .run_o(run_cmd_i));

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [31:0] got, input logic [31:0] e);
    cmp_count++;
    if (got !== e) begin
      fails++;
      $display("Error %0t read %h want %h", $time, got, e);
    end
  endtask : chk

  task automatic chk_pin(input logic [15:0] got, input logic [15:0] e);
    cmp_count++;
    if (got !== e) begin
      fails++;
      $display("Error %0t pin %h want %h", $time, got, e);
    end
  endtask : chk_pin

  task automatic ticks(input int n);
    repeat (n) @(posedge clk_i);
  endtask : ticks

  // holds the request until ack is sampled; a lost ack counts as a mismatch
  task automatic wb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'h1;
    stb_i <= 1'h1;
    we_i  <= w;
    adr_i <= ad;
    dat_i <= d;
    sel_i <= 4'hf;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'h1 && n < 20);
    if (n == 20) fails++;
    cyc_i <= 1'h0;
    stb_i <= 1'h0;
  endtask : wb

  task automatic rd(input logic [7:0] ad, input logic [31:0] e);
    exp_q.push_back(e);
    wb(1'h0, ad, 32'h0);
  endtask : rd

  task automatic set_cmd(input logic [3:0] v);
    @(posedge clk_i);
    cmd <= v;
  endtask : set_cmd

  task automatic wait_out(input udf_freq_t e);
    int n;
    n = 0;
    while (out_f !== e && n < 3000) begin
      @(posedge clk_i);
      n++;
    end
    chk_pin(16'(out_f), 16'(e));
  endtask : wait_out

  task automatic power_cycle;
    @(posedge clk_i);
    pd_i <= 1'h1;
    ticks(8);
    chk_pin(16'(out_f), 16'h0);
    pd_i <= 1'h0;
  endtask : power_cycle

  always @(posedge clk_i) begin
    noise <= 7'($random(seed));
    if (ack_o === 1'h1 && we_i === 1'h0 && exp_q.size() > 0) chk(dat_o, exp_q.pop_front());
  end

  always @(posedge clk_i) begin
    cyc_n++;
    if (cyc_n == 40000) begin
      fails++;
      end_of_test();
    end
  end

  initial begin
    ticks(8);
    rst_i <= 1'h0;
    rd(REG_CTRL, 32'h2);
    rd(REG_UPPER, 32'h3e8);
    rd(REG_LOWER, 32'h0);
    rd(REG_MASTER, 32'h0);
    rd(8'h30, 32'h0);
    wb(1'h1, REG_UPPER, 32'h7ff);
    rd(REG_UPPER, 32'h44c);
    a = 11'({$random(seed)} % 1101);
    wb(1'h1, REG_UPPER, {21'h0, a});
    rd(REG_UPPER, {21'h0, a});
    for (int i = 0; i < 4; i++) begin
      wb(1'h1, REG_FSEL0 + 8'(4 * cfg_t[i][11:10]), {24'h0, cfg_t[i][9:2]});
      ticks(3);
      chk_pin(16'(cfg_err), 16'(cfg_t[i][1]));
      chk_pin(16'(ms_dis), 16'(cfg_t[i][0]));
    end
    wb(1'h1, REG_UPPER, 32'h100);
    wb(1'h1, REG_LOWER, 32'h20);
    wb(1'h1, REG_MASTER, 32'h10);
    wb(1'h1, REG_ACCEL, 32'h10);
    wb(1'h1, REG_DECEL, 32'h10);
    ana <= 11'h30;
    set_cmd(4'h8);
    wait_out(11'h30);
    ticks(4);
    chk_pin(16'(agree), 16'h1);
    set_cmd(4'h9);
    ticks(20);
    rd(REG_MEM, 32'h0);
    wait_out(11'h100);
    set_cmd(4'ha);
    wait_out(11'h30);
    ana <= 11'h50;
    wait_out(11'h50);
    set_cmd(4'h0);
    power_cycle();
    wb(1'h1, REG_FSEL0, 32'h0);
    wb(1'h1, REG_FSEL0 + 8'h4, 32'h0);
    wb(1'h1, REG_FSEL0 + 8'h8, 32'ha);
    wb(1'h1, REG_UPPER, 32'h3e8);
    a = 11'h100 + 11'({$random(seed)} % 512);
    for (int hm = 0; hm < 2; hm++) begin
      wb(1'h1, REG_CTRL, 32'h2 | 32'(hm));
      ana <= a;
      set_cmd(4'h8);
      wait_out(a);
      set_cmd(4'hc);
      ticks(8);
      ana <= a >> 1;
      ticks(40);
      chk_pin(16'(out_f), 16'(a));
      set_cmd(4'h4);
      ticks(8);
      // without hold memory skip the power loss so a missing zero load shows
      if (hm) power_cycle();
      else chk_pin(16'(out_f), 16'(a));
      ana <= a;
      set_cmd(4'hc);
      ticks(20);
      chk_pin(16'(out_f), hm ? 16'(a) : 16'h0);
      set_cmd(4'h8);
      wait_out(a);
      set_cmd(4'h0);
      power_cycle();
    end
    // software run source, status and output read back
    wb(1'h1, REG_CTRL, 32'hc);
    wait_out(a);
    ticks(4);
    rd(REG_STATUS, 32'ha);
    rd(REG_OUT, {21'h0, a});
    end_of_test();
  end
endmodule : udf_top_tb_top
